/* src/dioct_top.sv */
// digital lines, three-channel counter/timer and status indicator
`timescale 1ns/10ps
module dioct_top #(
  parameter int BLINK_CYC = dioct_pkg::BLINK_CYC,
  parameter int ACT_HOLD_CYC = dioct_pkg::ACT_HOLD_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] line_in_i,
  output logic [15:0] line_out_o,
  output logic [15:0] line_oe_n_o,
  output logic [15:0] line_data_o,
  input wire logic dir_wr_i,
  input wire logic [1:0] dir_wdata_i,
  input wire logic [1:0] port_wr_i,
  input wire logic [15:0] port_wdata_i,
  input wire logic clk_sel_ext_i,
  input wire logic cnt_wr_i,
  input wire logic [1:0] cnt_sel_i,
  input wire logic [15:0] cnt_wdata_i,
  input wire logic cnt_mode_i,
  output logic [15:0] cnt_q_o,
  input wire logic ctr_clk_i,
  input wire logic ctr_gate_i,
  output logic ctr_out_o,
  input wire logic conv_en_i,
  output logic [1:0] conv_start_o,
  input wire logic usb_cfg_i,
  input wire logic usb_act_i,
  output logic led_o
);
  typedef enum logic [1:0] {LED_DARK, LED_STEADY, LED_BLINK} dioct_led_e;

  typedef struct packed {
    logic [1:0] dir_out;
    logic [15:0] out_data;
    logic [15:0] rd_data;
    logic [15:0] cnt_q;
    logic [6:0] acc;
    logic ref_tick;
    logic [3:0] ref_gap;
    logic ext_prev;
    logic ext_tick;
    dioct_led_e led_st;
    logic [23:0] blink_cnt;
    logic [23:0] act_cnt;
    logic led_ph;
    logic led;
  } dioct_top_s;

  dioct_top_s s_ff;
  dioct_top_s nxt_s;
  logic [15:0] cnt_now [dioct_pkg::NCHAN];
  logic [7:0] acc_sum;

  // one bit wider than the accumulator so the wrap test cannot overflow
  assign acc_sum = {1'b0, s_ff.acc} + {1'b0, dioct_pkg::ACC_STEP};

  dioct_chan_if ch_if [dioct_pkg::NCHAN] ();

  genvar g;
  generate
    for (g = 0; g < dioct_pkg::NCHAN; g++)
    begin : g_chan
      assign ch_if[g].load = cnt_wr_i && (cnt_sel_i == 2'(g));
      assign ch_if[g].val = cnt_wdata_i;
      assign ch_if[g].mode = cnt_mode_i;
      assign cnt_now[g] = ch_if[g].count;
      if (g == 0)
      begin : g_gp
        // general channel: selectable clock and connector gate
        assign ch_if[g].tick = clk_sel_ext_i ? s_ff.ext_tick : s_ff.ref_tick;
        assign ch_if[g].gate = ctr_gate_i;
      end
      else
      begin : g_conv
        // pacing channels stay on the internal reference
        assign ch_if[g].tick = s_ff.ref_tick;
        assign ch_if[g].gate = conv_en_i;
        assign conv_start_o[g - 1] = ch_if[g].tc;
      end
      dioct_chan u_chan (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ch(ch_if[g])
      );
    end
  endgenerate

  assign ctr_out_o = ch_if[0].out;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.ref_tick = 1'b0;
    if (dir_wr_i)
      nxt_s.dir_out = dir_wdata_i;
    for (int p = 0; p < dioct_pkg::PORTS; p++)
    begin
      if (port_wr_i[p])
        nxt_s.out_data[p * 8 +: 8] = port_wdata_i[p * 8 +: 8];
    end
    nxt_s.rd_data = line_in_i;
    nxt_s.cnt_q = (cnt_sel_i < 2'(dioct_pkg::NCHAN)) ? cnt_now[cnt_sel_i] : 16'h0000;
    // exact 10/125 average rate; jitter of one system clock is accepted
    if (acc_sum >= {1'b0, dioct_pkg::ACC_WRAP})
    begin
      nxt_s.acc = 7'(acc_sum - {1'b0, dioct_pkg::ACC_WRAP});
      nxt_s.ref_tick = 1'b1;
    end
    else
      nxt_s.acc = acc_sum[6:0];
    // cycles since the last reference tick; zero until the first one
    if (s_ff.ref_tick)
      nxt_s.ref_gap = 4'h1;
    else if (s_ff.ref_gap != 4'h0 && s_ff.ref_gap != 4'hF)
      nxt_s.ref_gap = s_ff.ref_gap + 4'h1;
    // sampled edge detect only works while the pin stays slow
    nxt_s.ext_prev = ctr_clk_i;
    nxt_s.ext_tick = ctr_clk_i && !s_ff.ext_prev;
    if (usb_act_i)
      nxt_s.act_cnt = 24'(ACT_HOLD_CYC);
    else if (s_ff.act_cnt != 24'h000000)
      nxt_s.act_cnt = s_ff.act_cnt - 24'h000001;
    if (s_ff.blink_cnt >= 24'(BLINK_CYC - 1))
    begin
      nxt_s.blink_cnt = 24'h000000;
      nxt_s.led_ph = ~s_ff.led_ph;
    end
    else
      nxt_s.blink_cnt = s_ff.blink_cnt + 24'h000001;
    case (s_ff.led_st)
      LED_DARK:
      begin
        if (usb_cfg_i && usb_act_i)
        begin
          nxt_s.led_st = LED_BLINK;
          nxt_s.blink_cnt = 24'h000000;
          nxt_s.led_ph = 1'b0;
        end
        else if (usb_cfg_i)
          nxt_s.led_st = LED_STEADY;
      end
      LED_STEADY:
      begin
        if (!usb_cfg_i)
          nxt_s.led_st = LED_DARK;
        else if (usb_act_i)
        begin
          nxt_s.led_st = LED_BLINK;
          nxt_s.blink_cnt = 24'h000000;
          nxt_s.led_ph = 1'b0;
        end
      end
      LED_BLINK:
      begin
        if (!usb_cfg_i)
          nxt_s.led_st = LED_DARK;
        else if (s_ff.act_cnt == 24'h000000 && !usb_act_i)
          nxt_s.led_st = LED_STEADY;
      end
      default: nxt_s.led_st = LED_DARK;
    endcase
    case (nxt_s.led_st)
      LED_STEADY: nxt_s.led = 1'b1;
      LED_BLINK: nxt_s.led = nxt_s.led_ph;
      default: nxt_s.led = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_ff <= '0;
      s_ff.dir_out <= dioct_pkg::DIR_RST;
      s_ff.out_data <= dioct_pkg::LINE_OUT_RST;
      // the clock pin idles at its pull-up level, so no false edge after reset
      s_ff.ext_prev <= 1'b1;
      s_ff.led_st <= LED_DARK;
    end
    else
      s_ff <= nxt_s;
  end

  // enable is low while driving; a 0 data bit sinks the pin low
  assign line_oe_n_o = {{8{~s_ff.dir_out[1]}}, {8{~s_ff.dir_out[0]}}};
  assign line_out_o = s_ff.out_data;
  assign line_data_o = s_ff.rd_data;
  assign cnt_q_o = s_ff.cnt_q;
  assign led_o = s_ff.led;

  a_port_split: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (dir_wr_i && dir_wdata_i == 2'h1)
      |=> (line_oe_n_o[7:0] == 8'h00) && (line_oe_n_o[15:8] == 8'hFF))
    else $error("port directions not independent");

  a_byte_lanes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (port_wr_i == 2'h2) |=> (line_out_o[15:8] == $past(port_wdata_i[15:8]))
      && (line_out_o[7:0] == $past(line_out_o[7:0])))
    else $error("upper byte write touched lower port");

  a_read_level: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rst_n_i |=> line_data_o == $past(line_in_i))
    else $error("read back does not follow pin level");

  a_ref_spacing: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_ff.ref_gap != 4'h0) |-> (s_ff.ref_gap <= dioct_pkg::REF_GAP_MAX)
      && (!s_ff.ref_tick || s_ff.ref_gap >= dioct_pkg::REF_GAP_MIN))
    else $error("internal reference spacing outside 12 to 13 cycles");

  a_ext_select: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (clk_sel_ext_i && ctr_clk_i && !s_ff.ext_prev)
      |=> s_ff.ext_tick && (!clk_sel_ext_i || ch_if[0].tick))
    else $error("external clock edge not routed");

  a_conv_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !conv_en_i && !(cnt_wr_i && cnt_sel_i != 2'h0) |=> conv_start_o == 2'h0)
    else $error("conversion start while pacing disabled");

  a_led_steady: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (usb_cfg_i && s_ff.led_st == LED_STEADY && !usb_act_i) |=> led_o)
    else $error("indicator not steady when configured");

  a_led_blink: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (usb_cfg_i && usb_act_i) ##1 usb_cfg_i |=> s_ff.led_st == LED_BLINK)
    else $error("indicator not blinking during transfers");

  a_reset_input: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> line_oe_n_o == 16'hFFFF)
    else $error("lines driven after reset");
endmodule

/* src/dioct_pkg.sv */
// constants shared by the digital line and counter/timer block
package dioct_pkg;
  localparam int LINES = 16;
  localparam int PORT_W = 8;
  localparam int PORTS = 2;
  localparam int CNT_W = 16;
  localparam int NCHAN = 3;
  localparam int CLK_MHZ = 125;
  localparam int REF_MHZ = 10;
  localparam int EXT_MAX_MHZ = 10;
  localparam logic [6:0] ACC_STEP = 7'(REF_MHZ);
  localparam logic [6:0] ACC_WRAP = 7'(CLK_MHZ);
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam logic [15:0] LINE_OUT_RST = 16'hFFFF;
  localparam int BLINK_HALF_MS = 50;
  localparam int BLINK_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
  localparam int ACT_HOLD_CYC = 2 * BLINK_CYC;
  localparam int TMR_W = 24;
  localparam logic [3:0] REF_GAP_MIN = 4'hC;
  localparam logic [3:0] REF_GAP_MAX = 4'hD;
endpackage

/* src/dioct_chan_if.sv */
// control and result signals between the top and one counter channel
`timescale 1ns/10ps
interface dioct_chan_if;
  logic tick;
  logic gate;
  logic load;
  logic [15:0] val;
  logic mode;
  logic out;
  logic tc;
  logic [15:0] count;
  modport ctl (output tick, output gate, output load, output val, output mode,
               input out, input tc, input count);
  modport chan (input tick, input gate, input load, input val, input mode,
                output out, output tc, output count);
endinterface

/* src/dioct_chan.sv */
// one 16-bit down counter channel with one-shot and rate modes
`timescale 1ns/10ps
module dioct_chan (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  dioct_chan_if.chan ch
);
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic mode;
    logic running;
    logic out;
    logic tc;
  } dioct_chan_s;

  dioct_chan_s s_ff;
  dioct_chan_s nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tc = 1'b0;
    if (ch.load)
    begin
      nxt_s.count = ch.val;
      nxt_s.reload = ch.val;
      nxt_s.mode = ch.mode;
      nxt_s.running = 1'b1;
      nxt_s.out = ch.mode;
    end
    else if (ch.tick && ch.gate && s_ff.running)
    begin
      if (s_ff.count <= 16'h0001)
      begin
        nxt_s.tc = 1'b1;
        if (s_ff.mode)
        begin
          // rate mode: reload and toggle gives a square wave
          nxt_s.count = s_ff.reload;
          nxt_s.out = ~s_ff.out;
        end
        else
        begin
          nxt_s.count = 16'h0000;
          nxt_s.out = 1'b1;
          nxt_s.running = 1'b0;
        end
      end
      else
      begin
        nxt_s.count = s_ff.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign ch.out = s_ff.out;
  assign ch.tc = s_ff.tc;
  assign ch.count = s_ff.count;

  a_load_takes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ch.load |=> (ch.count == $past(ch.val)) && s_ff.running)
    else $error("load value not taken");

  a_count_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!ch.load && ch.tick && ch.gate && s_ff.running && ch.count > 16'h0001)
      |=> ch.count == $past(ch.count) - 16'h0001)
    else $error("counter did not step down by one");

  a_gate_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!ch.load && !ch.gate) |=> $stable(ch.count) && !ch.tc)
    else $error("counter moved with gate low");
endmodule

/* verif/dioct_field.sv */
// field side: pulled-up digital pins and external counter clock source
`timescale 1ns/10ps
module dioct_field (
  input wire logic sys_clk_i,
  input wire logic [15:0] line_out_i,
  input wire logic [15:0] line_oe_n_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] ext_en_i,
  input wire logic clk_run_i,
  output logic [15:0] pin_o,
  output logic ctr_clk_o
);
  int div = 0;
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      // a released pin follows ext_val_i where ext_en_i is set, else floats to the pull-up level
      pin_o[i] = !line_oe_n_i[i] ? line_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
    end
  end
  // 14 cycles a period keeps the source below 10 MHz; idles at the pull-up level
  initial ctr_clk_o = 1'b1;
  always @(posedge sys_clk_i)
  begin
    div <= (clk_run_i && div < 6) ? div + 1 : 0;
    if (!clk_run_i)
      ctr_clk_o <= 1'b1;
    else if (div == 6)
      ctr_clk_o <= ~ctr_clk_o;
  end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the digital line and counter/timer block
`timescale 1ns/10ps
module tb_top;
  logic sys_clk_i = 0, rst_n_i = 0, dir_wr_i = 0, clk_sel_ext_i = 0, cnt_wr_i = 0;
  logic cnt_mode_i = 0, ctr_gate_i = 0, conv_en_i = 0, usb_cfg_i = 0, usb_act_i = 0;
  logic clk_run = 0, ctr_clk_i, ctr_out_o, led_o, prev;
  logic [1:0] dir_wdata_i = 0, port_wr_i = 0, cnt_sel_i = 0, conv_start_o, mdir = 0;
  logic [15:0] port_wdata_i = 0, cnt_wdata_i = 0, ext_val = 0, ext_en = 0, mout = 16'hFFFF;
  logic [15:0] line_in_i, line_out_o, line_oe_n_o, line_data_o, cnt_q_o, oen;
  int bad_count = 0, comparisons = 0, seed = 32'hc801, n, t, edges, p1, p2;
  dioct_top #(.BLINK_CYC(8), .ACT_HOLD_CYC(32)) u_dut (.sys_clk_i, .rst_n_i, .line_in_i,
    .line_out_o, .line_oe_n_o, .line_data_o, .dir_wr_i, .dir_wdata_i, .port_wr_i,
    .port_wdata_i, .clk_sel_ext_i, .cnt_wr_i, .cnt_sel_i, .cnt_wdata_i, .cnt_mode_i,
    .cnt_q_o, .ctr_clk_i, .ctr_gate_i, .ctr_out_o, .conv_en_i, .conv_start_o, .usb_cfg_i,
    .usb_act_i, .led_o);
  dioct_field u_field (.sys_clk_i, .line_out_i(line_out_o), .line_oe_n_i(line_oe_n_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .clk_run_i(clk_run), .pin_o(line_in_i),
    .ctr_clk_o(ctr_clk_i));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge ctr_clk_i) edges++;
  always @(negedge sys_clk_i)
  begin
    p1 += (conv_start_o[0] === 1'b1);
    p2 += (conv_start_o[1] === 1'b1);
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task automatic smp(int k);
    cyc(k);
    @(negedge sys_clk_i);
  endtask
  task automatic wdir(logic [1:0] d);
    @(posedge sys_clk_i);
    dir_wr_i <= 1'b1;
    dir_wdata_i <= d;
    @(posedge sys_clk_i);
    dir_wr_i <= 1'b0;
    mdir = d;
  endtask
  task automatic wport(logic [1:0] s, logic [15:0] d);
    @(posedge sys_clk_i);
    port_wr_i <= s;
    port_wdata_i <= d;
    @(posedge sys_clk_i);
    port_wr_i <= 2'h0;
    if (s[0]) mout[7:0] = d[7:0];
    if (s[1]) mout[15:8] = d[15:8];
  endtask
  task automatic load(logic [1:0] s, logic [15:0] v, logic m);
    @(posedge sys_clk_i);
    cnt_wr_i <= 1'b1;
    cnt_sel_i <= s;
    cnt_wdata_i <= v;
    cnt_mode_i <= m;
    @(posedge sys_clk_i);
    cnt_wr_i <= 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    cyc(20);
    rst_n_i <= 1'b1;
    smp(0);
    check("oe_n", line_oe_n_o, 16'hFFFF);
    check("led", {15'h0, led_o}, 16'h0);
    cyc(1);
    ext_en <= 16'hFFFF;
    for (int i = 0; i < 8; i++)
    begin
      wdir(2'($random(seed)));
      wport(2'($random(seed)), 16'($random(seed)));
      ext_val <= 16'($random(seed));
      smp(2);
      oen = {{8{~mdir[1]}}, {8{~mdir[0]}}};
      check("oe_n", line_oe_n_o, oen);
      check("out", line_out_o, mout);
      check("data", line_data_o, (mout & ~oen) | (ext_val & oen));
    end
    wdir(2'h0);
    ext_en <= 16'h0;
    smp(2);
    check("pullup", line_data_o, 16'hFFFF);
    cyc(1);
    clk_sel_ext_i <= 1'b1;
    ctr_gate_i <= 1'b1;
    load(2'h0, 16'h0005, 1'b0);
    smp(1);
    check("out run", {15'h0, ctr_out_o}, 16'h0);
    cyc(1);
    edges = 0;
    clk_run <= 1'b1;
    for (t = 0; t < 300 && ctr_out_o !== 1'b1; t++) smp(1);
    smp(1);
    check("out end", {15'h0, ctr_out_o}, 16'h1);
    check("edges", 16'(edges), 16'h0005);
    check("count end", cnt_q_o, 16'h0);
    cyc(1);
    ctr_gate_i <= 1'b0;
    load(2'h0, 16'h0009, 1'b0);
    smp(100);
    check("gated", cnt_q_o, 16'h0009);
    cyc(1);
    clk_run <= 1'b0;
    clk_sel_ext_i <= 1'b0;
    ctr_gate_i <= 1'b1;
    load(2'h0, 16'h00C8, 1'b0);
    smp(250);
    check("int ticks", 16'(cnt_q_o >= 179 && cnt_q_o <= 181), 16'h1);
    load(2'h3, 16'h1234, 1'b0);
    smp(2);
    check("sel3", cnt_q_o, 16'h0);
    load(2'h1, 16'h0004, 1'b1);
    load(2'h2, 16'h0005, 1'b1);
    p1 = 0;
    p2 = 0;
    smp(250);
    check("conv off", 16'(p1 + p2), 16'h0);
    cyc(1);
    conv_en_i <= 1'b1;
    smp(0);
    p1 = 0;
    p2 = 0;
    smp(500);
    check("conv1", 16'(p1 >= 9 && p1 <= 11), 16'h1);
    check("conv2", 16'(p2 >= 7 && p2 <= 9), 16'h1);
    cyc(1);
    usb_cfg_i <= 1'b1;
    smp(3);
    check("steady", {15'h0, led_o}, 16'h1);
    cyc(1);
    usb_act_i <= 1'b1;
    cyc(1);
    usb_act_i <= 1'b0;
    smp(0);
    n = 0;
    prev = led_o;
    for (int i = 0; i < 40; i++)
    begin
      smp(1);
      n += (led_o !== prev);
      prev = led_o;
    end
    check("blink", 16'(n >= 3), 16'h1);
    smp(80);
    check("steady", {15'h0, led_o}, 16'h1);
    cyc(1);
    usb_cfg_i <= 1'b0;
    smp(3);
    check("dark", {15'h0, led_o}, 16'h0);
    stop_test();
  end
endmodule
